// [logic/dhci_pkg.sv]
// shared constants and types of the dac host command interface
package dhci_pkg;

  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;          // bits in one serial frame
  localparam int DATA_BITS = 14;           // data field width
  localparam int TOP_BITS = 10;            // address echo width
  localparam int BIT_BANK = 23;            // toggle bank select
  localparam int BIT_RW = 22;              // read/write bit
  localparam int CHAN_LSB = 16;            // channel address low bit
  localparam int REG_LSB = 14;             // register select low bit
  localparam logic [4:0] FRAME_CNT = 5'h18; // frame length as a count
  localparam logic [23:0] NO_OPERATION_WORD = 24'h000000;

  // ----------------------------------------
  // two-wire slave constants
  // ----------------------------------------
  localparam logic [4:0] TW_ADDR_FIXED = 5'h15; // upper slave address bits
  localparam logic [7:0] TW_BURST_PTR = 8'hFF;  // pointer that starts burst
  localparam logic [5:0] TW_LAST_CHAN = 6'h27;  // last burst channel
  localparam logic [3:0] TW_ACK_BIT = 4'h8;     // bits before acknowledge
  localparam int TW_MAX_KHZ = 400;              // fastest bus clock served
  localparam int CLK_MHZ = 100;                 // core clock rate
  // core cycles in one half period of the fastest bus clock
  localparam int TW_HALF_CYC = (CLK_MHZ * 1000) / (2 * TW_MAX_KHZ);

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [5:0] CHAN_RST = 6'h00;
  localparam logic [1:0] REG_RST = 2'h0;
  localparam logic [13:0] DATA_RST = 14'h0000;

  // two-wire receiver states
  typedef enum logic [5:0] {
    TW_IDLE = 6'h01,
    TW_ADDR = 6'h02,
    TW_PTR = 6'h04,
    TW_MSB = 6'h08,
    TW_LSB = 6'h10,
    TW_SKIP = 6'h20
  } dhci_tw_state_t;

endpackage

// [logic/dhci_top.sv]
// host command interface of a multi-channel dac: serial, two-wire, parallel
`timescale 1ns/1ps
module dhci_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // interface selection pins
  input wire logic port_type_select_i,
  input wire logic proto_sel_i,
  // synchronous serial port
  input wire logic sync_b_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic readback_out_o,
  // two-wire port, data line split three ways
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_high_i,
  input wire logic addr_strap_low_i,
  // parallel port
  input wire logic cs_b_i,
  input wire logic wr_b_i,
  input wire logic target_reg_sel_high_i,
  input wire logic target_reg_sel_low_i,
  input wire logic [5:0] channel_address_i,
  input wire logic [13:0] data_word_i,
  // readback lookup into the register store
  output logic rd_bank_o,
  output logic [5:0] rd_chan_o,
  output logic [1:0] rd_reg_o,
  input wire logic [13:0] rd_data_i,
  // register write request
  output logic wr_stb_o,
  output logic wr_bank_o,
  output logic [5:0] wr_chan_o,
  output logic [1:0] wr_reg_o,
  output logic [13:0] wr_data_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PW = 33; // synchronised pin count

  logic [PW-1:0] pin_raw;   // all pins from outside except clock and reset
  logic [PW-1:0] meta_r;    // first stage, read only by second
  logic [PW-1:0] pin_s_r;   // second stage, safe to use
  logic [PW-1:0] pin_q_r;   // one sample older, for edges

  assign pin_raw = {port_type_select_i, proto_sel_i, sync_b_i, sclk_i, din_i,
                    scl_i, sda_i, addr_strap_high_i, addr_strap_low_i,
                    cs_b_i, wr_b_i, target_reg_sel_high_i, target_reg_sel_low_i,
                    channel_address_i, data_word_i};

  // two flops per pin, plus an edge history stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= '1;
      pin_s_r <= '1;
      pin_q_r <= '1;
    end
    else
    begin
      meta_r <= pin_raw;
      pin_s_r <= meta_r;
      pin_q_r <= pin_s_r;
    end
  end

  // named views of the synchronised pins
  logic pts_s, prot_s, sync_s, sync_q, sclk_s, sclk_q, din_s;
  logic scl_s, sda_s, cs_q, wr_s, wr_q;
  logic [1:0] strap_s, preg_q;
  logic [5:0] pch_q;
  logic [13:0] pdat_q;

  assign pts_s = pin_s_r[32];
  assign prot_s = pin_s_r[31];
  assign sync_s = pin_s_r[30];
  assign sync_q = pin_q_r[30];
  assign sclk_s = pin_s_r[29];
  assign sclk_q = pin_q_r[29];
  assign din_s = pin_s_r[28];
  assign scl_s = pin_s_r[27];
  assign sda_s = pin_s_r[26];
  assign strap_s = pin_s_r[25:24];
  assign cs_q = pin_q_r[23];
  assign wr_s = pin_s_r[22];
  assign wr_q = pin_q_r[22];
  // parallel fields taken one sample back, while strobe was still low
  assign preg_q = pin_q_r[21:20];
  assign pch_q = pin_q_r[19:14];
  assign pdat_q = pin_q_r[13:0];

  // ----------------------------------------
  // interface selection
  // ----------------------------------------
  logic sp_en, tw_en, par_en;

  assign sp_en = pts_s & ~prot_s;
  assign tw_en = pts_s & prot_s;
  assign par_en = ~pts_s;

  // ----------------------------------------
  // synchronous serial port
  // ----------------------------------------
  logic [23:0] in_sr_r, in_sr_nxt;   // received frame
  logic [4:0] cnt_r, cnt_nxt;        // falling edges seen
  logic [23:0] out_sr_r, out_sr_nxt; // readback shifter
  logic pend_r, pend_nxt;            // read request waiting
  logic [9:0] top_r, top_nxt;        // address of the request
  logic sp_wr;                       // complete write frame
  logic fr_start, fr_end, s_rise, s_fall;

  assign fr_start = ~sync_s & sync_q;
  assign fr_end = sync_s & ~sync_q;
  assign s_rise = sclk_s & ~sclk_q;
  assign s_fall = ~sclk_s & sclk_q;

  // next state of the serial port
  always_comb
  begin
    in_sr_nxt = in_sr_r;
    cnt_nxt = cnt_r;
    out_sr_nxt = out_sr_r;
    pend_nxt = pend_r;
    top_nxt = top_r;
    sp_wr = 1'b0;
    if (!sp_en)
    begin
      // port switched off: nothing waits, nothing shifts
      cnt_nxt = 5'h00;
      pend_nxt = 1'b0;
      out_sr_nxt = dhci_pkg::NO_OPERATION_WORD;
    end
    else if (fr_start)
    begin
      // first bit appears at sync fall, needs no clock edge
      cnt_nxt = 5'h00;
      if (pend_r)
      begin
        out_sr_nxt = {top_r, rd_data_i};
      end
      else
      begin
        out_sr_nxt = dhci_pkg::NO_OPERATION_WORD;
      end
    end
    else if (!sync_s)
    begin
      if (s_fall && cnt_r < dhci_pkg::FRAME_CNT)
      begin
        // bits beyond the frame length are ignored
        in_sr_nxt = {in_sr_r[22:0], din_s};
        cnt_nxt = cnt_r + 5'h01;
      end
      if (s_rise && cnt_r != 5'h00)
      begin
        // shift on rising edge, valid at the next fall
        out_sr_nxt = {out_sr_r[22:0], 1'b0};
      end
    end
    else if (fr_end && cnt_r == dhci_pkg::FRAME_CNT)
    begin
      // short frames are discarded
      pend_nxt = in_sr_r[dhci_pkg::BIT_RW];
      if (in_sr_r[dhci_pkg::BIT_RW])
      begin
        // keep only address fields, data bits are ignored
        top_nxt = in_sr_r[23:14];
      end
      else
      begin
        sp_wr = 1'b1;
      end
    end
  end

  // registers of the serial port
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      in_sr_r <= 24'h000000;
      cnt_r <= 5'h00;
      out_sr_r <= dhci_pkg::NO_OPERATION_WORD;
      pend_r <= 1'b0;
      top_r <= 10'h000;
    end
    else
    begin
      in_sr_r <= in_sr_nxt;
      cnt_r <= cnt_nxt;
      out_sr_r <= out_sr_nxt;
      pend_r <= pend_nxt;
      top_r <= top_nxt;
    end
  end

  assign readback_out_o = out_sr_r[23];
  assign rd_bank_o = top_r[9];
  assign rd_chan_o = top_r[7:2];
  assign rd_reg_o = top_r[1:0];

  // ----------------------------------------
  // two-wire slave
  // ----------------------------------------
  logic tw_wr, tw_ack;
  logic [5:0] tw_chan;
  logic [1:0] tw_reg;
  logic [13:0] tw_data;

  // sampled at 100 MHz, ample for a 400 kHz bus
  dhci_twi_rx i_dhci_twi_rx (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(tw_en),
    .strap_i(strap_s),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .ack_o(tw_ack),
    .wr_o(tw_wr),
    .chan_o(tw_chan),
    .reg_o(tw_reg),
    .data_o(tw_data)
  );

  // slave only pulls data low; clock is never driven
  assign sda_o = 1'b0;
  assign sda_oe_o = tw_ack;

  // ----------------------------------------
  // parallel port
  // ----------------------------------------
  logic par_wr;

  // strobe rising edge while chip select was low
  assign par_wr = par_en & wr_s & ~wr_q & ~cs_q;

  // ----------------------------------------
  // write request merge
  // ----------------------------------------
  logic wstb_r, wstb_nxt;
  logic wbank_r, wbank_nxt;
  logic [5:0] wch_r, wch_nxt;
  logic [1:0] wrg_r, wrg_nxt;
  logic [13:0] wdat_r, wdat_nxt;

  // only one interface is live, so no two writes meet
  always_comb
  begin
    wstb_nxt = 1'b0;
    wbank_nxt = wbank_r;
    wch_nxt = wch_r;
    wrg_nxt = wrg_r;
    wdat_nxt = wdat_r;
    if (sp_wr)
    begin
      wstb_nxt = 1'b1;
      wbank_nxt = in_sr_r[dhci_pkg::BIT_BANK];
      wch_nxt = in_sr_r[21:16];
      wrg_nxt = in_sr_r[15:14];
      wdat_nxt = in_sr_r[13:0];
    end
    else if (tw_wr)
    begin
      // two-wire words carry no bank bit: normal path only
      wstb_nxt = 1'b1;
      wbank_nxt = 1'b0;
      wch_nxt = tw_chan;
      wrg_nxt = tw_reg;
      wdat_nxt = tw_data;
    end
    else if (par_wr)
    begin
      wstb_nxt = 1'b1;
      wbank_nxt = 1'b0;
      wch_nxt = pch_q;
      wrg_nxt = preg_q;
      wdat_nxt = pdat_q;
    end
  end

  // registered write request
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wstb_r <= 1'b0;
      wbank_r <= 1'b0;
      wch_r <= dhci_pkg::CHAN_RST;
      wrg_r <= dhci_pkg::REG_RST;
      wdat_r <= dhci_pkg::DATA_RST;
    end
    else
    begin
      wstb_r <= wstb_nxt;
      wbank_r <= wbank_nxt;
      wch_r <= wch_nxt;
      wrg_r <= wrg_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  assign wr_stb_o = wstb_r;
  assign wr_bank_o = wbank_r;
  assign wr_chan_o = wch_r;
  assign wr_reg_o = wrg_r;
  assign wr_data_o = wdat_r;

endmodule // dhci_top

// [logic/dhci_twi_rx.sv]
// receive-only two-wire slave of the dac host command interface
`timescale 1ns/1ps
module dhci_twi_rx (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic en_i,
  input wire logic [1:0] strap_i,
  // synchronised bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic ack_o,
  // word out
  output logic wr_o,
  output logic [5:0] chan_o,
  output logic [1:0] reg_o,
  output logic [13:0] data_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  dhci_pkg::dhci_tw_state_t st_r, st_nxt;
  logic scl_q_r, sda_q_r;           // previous line samples
  logic [7:0] sh_r, sh_nxt;         // byte shifter
  logic [3:0] bit_r, bit_nxt;       // bits of this byte
  logic in_ack_r, in_ack_nxt;       // ninth clock in progress
  logic ack_r, ack_nxt;             // pulling data low
  logic burst_r, burst_nxt;         // auto-increment active
  logic [5:0] ch_r, ch_nxt;         // channel pointer
  logic [1:0] rg_r, rg_nxt;         // held register select
  logic [5:0] hi_r, hi_nxt;         // held upper data bits
  logic wr_r, wr_nxt;
  logic [13:0] dat_r, dat_nxt;
  logic start, stop, rise, fall;

  assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign rise = scl_i & ~scl_q_r;
  assign fall = ~scl_i & scl_q_r;

  // next state of the byte engine
  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    in_ack_nxt = in_ack_r;
    ack_nxt = ack_r;
    burst_nxt = burst_r;
    ch_nxt = ch_r;
    rg_nxt = rg_r;
    hi_nxt = hi_r;
    wr_nxt = 1'b0;
    dat_nxt = dat_r;
    if (!en_i || stop)
    begin
      // off, or stop ends any write mode
      st_nxt = dhci_pkg::TW_IDLE;
      burst_nxt = 1'b0;
      bit_nxt = 4'h0;
      in_ack_nxt = 1'b0;
      ack_nxt = 1'b0;
    end
    else if (start)
    begin
      // start or repeated start keeps us on the bus
      st_nxt = dhci_pkg::TW_ADDR;
      burst_nxt = 1'b0;
      bit_nxt = 4'h0;
      in_ack_nxt = 1'b0;
      ack_nxt = 1'b0;
    end
    else if (st_r != dhci_pkg::TW_IDLE)
    begin
      if (rise && bit_r < dhci_pkg::TW_ACK_BIT)
      begin
        // one bit per clock, msb first
        sh_nxt = {sh_r[6:0], sda_i};
        bit_nxt = bit_r + 4'h1;
      end
      if (fall && in_ack_r)
      begin
        // end of the ninth clock: release the line
        in_ack_nxt = 1'b0;
        ack_nxt = 1'b0;
        bit_nxt = 4'h0;
      end
      else if (fall && bit_r == dhci_pkg::TW_ACK_BIT)
      begin
        in_ack_nxt = 1'b1;
        unique case (st_r)
          dhci_pkg::TW_ADDR:
          begin
            // own address with write direction only
            if (sh_r == {dhci_pkg::TW_ADDR_FIXED, strap_i, 1'b0})
            begin
              ack_nxt = 1'b1;
              st_nxt = dhci_pkg::TW_PTR;
            end
            else
            begin
              st_nxt = dhci_pkg::TW_SKIP;
            end
          end
          dhci_pkg::TW_PTR:
          begin
            ack_nxt = 1'b1;
            st_nxt = dhci_pkg::TW_MSB;
            burst_nxt = (sh_r == dhci_pkg::TW_BURST_PTR);
            ch_nxt = (sh_r == dhci_pkg::TW_BURST_PTR) ? dhci_pkg::CHAN_RST : sh_r[5:0];
          end
          dhci_pkg::TW_MSB:
          begin
            ack_nxt = 1'b1;
            rg_nxt = sh_r[7:6];
            hi_nxt = sh_r[5:0];
            st_nxt = dhci_pkg::TW_LSB;
          end
          dhci_pkg::TW_LSB:
          begin
            ack_nxt = 1'b1;
            wr_nxt = 1'b1;
            dat_nxt = {hi_r, sh_r};
            if (burst_r && ch_r != dhci_pkg::TW_LAST_CHAN)
            begin
              st_nxt = dhci_pkg::TW_MSB;
            end
            else
            begin
              // three-byte mode expects a new pointer
              st_nxt = dhci_pkg::TW_PTR;
              burst_nxt = 1'b0;
            end
          end
          default:
          begin
            ack_nxt = 1'b0;
          end
        endcase
      end
      if (wr_r && burst_r)
      begin
        ch_nxt = ch_r + 6'h01;
      end
    end
  end

  // registers of the byte engine
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= dhci_pkg::TW_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      in_ack_r <= 1'b0;
      ack_r <= 1'b0;
      burst_r <= 1'b0;
      ch_r <= dhci_pkg::CHAN_RST;
      rg_r <= dhci_pkg::REG_RST;
      hi_r <= 6'h00;
      wr_r <= 1'b0;
      dat_r <= dhci_pkg::DATA_RST;
    end
    else
    begin
      st_r <= st_nxt;
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      in_ack_r <= in_ack_nxt;
      ack_r <= ack_nxt;
      burst_r <= burst_nxt;
      ch_r <= ch_nxt;
      rg_r <= rg_nxt;
      hi_r <= hi_nxt;
      wr_r <= wr_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign wr_o = wr_r;
  assign chan_o = ch_r;
  assign reg_o = rg_r;
  assign data_o = dat_r;

endmodule // dhci_twi_rx

// [tb/dhci_host_model.sv]
// host model: serial master, two-wire master and parallel writer
`timescale 1ns/1ps
module dhci_host_model (
  // clock and answers
  input wire logic clk_i,
  input wire logic readback_out_i,
  input wire logic sda_i,
  // serial and two-wire lines
  output logic sync_b_o,
  output logic sclk_o,
  output logic din_o,
  output logic scl_o,
  output logic sda_low_o,
  // parallel port
  output logic cs_b_o,
  output logic wr_b_o,
  output logic [1:0] reg_sel_o,
  output logic [5:0] chan_o,
  output logic [13:0] data_o
);
  // ----------------------------------------
  // idle levels and bus tasks
  // ----------------------------------------
  initial
  begin
    {sync_b_o, sclk_o, din_o, scl_o, sda_low_o, cs_b_o, wr_b_o} = 7'h6B;
    {reg_sel_o, chan_o, data_o} = 22'h000000;
  end
  // wait n cycles, land just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // framed transfer, clock idles high, readback sampled late in low phase
  task automatic spi_frame(input logic [23:0] w, input int n, output logic [23:0] rb);
    rb = 24'h000000;
    sync_b_o = 1'b0;
    din_o = w[23];
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b0;
      tick(4);
      rb = {rb[22:0], readback_out_i};
      sclk_o = 1'b1;
      din_o = (i < 23) ? w[22 - i] : ~din_o;
      tick(4);
    end
    sync_b_o = 1'b1;
    din_o = ~din_o;
    tick(8);
  endtask
  // start or repeated start, scl left low
  task automatic tw_start();
    sda_low_o = 1'b0;
    tick(7);
    scl_o = 1'b1;
    tick(5);
    sda_low_o = 1'b1;
    tick(5);
    scl_o = 1'b0;
  endtask
  // stop, bus released
  task automatic tw_stop();
    sda_low_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    sda_low_o = 1'b0;
    tick(10);
  endtask
  // one byte msb first, ninth bit released and returned as ack level
  task automatic tw_byte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 9; i++)
    begin
      tick(5);
      sda_low_o = (i < 8) ? !b[7 - i] : 1'b0;
      tick(5);
      scl_o = 1'b1;
      tick(9);
      ack = sda_i;
      tick(1);
      scl_o = 1'b0;
    end
  endtask
  // parallel write, fields held around the strobe rise
  task automatic par_write(input logic cs, input logic [1:0] rg, input logic [5:0] ch, input logic [13:0] d);
    cs_b_o = cs;
    reg_sel_o = rg;
    chan_o = ch;
    data_o = d;
    tick(4);
    wr_b_o = 1'b0;
    tick(4);
    wr_b_o = 1'b1;
    tick(6);
    cs_b_o = 1'b1;
    data_o = ~d;
    tick(4);
  endtask
endmodule // dhci_host_model

// [tb/dhci_top_monitor.sv]
// port checker of the dac host command interface
`timescale 1ns/1ps
module dhci_top_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // selection, two-wire and readback lines
  input wire logic port_type_select_i,
  input wire logic proto_sel_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic readback_out_o,
  // parallel port
  input wire logic cs_b_i,
  input wire logic wr_b_i,
  input wire logic target_reg_sel_high_i,
  input wire logic target_reg_sel_low_i,
  input wire logic [5:0] channel_address_i,
  input wire logic [13:0] data_word_i,
  // write request
  input wire logic wr_stb_o,
  input wire logic wr_bank_o,
  input wire logic [5:0] wr_chan_o,
  input wire logic [1:0] wr_reg_o,
  input wire logic [13:0] wr_data_o
);
  // ----------------------------------------
  // relations between ports
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o)
    else $error("write strobe wider than one cycle");
  par_strobe_a: assert property (!port_type_select_i && !$past(port_type_select_i, 4)
    && $rose(wr_b_i) && !cs_b_i |-> ##[3:5] wr_stb_o) else $error("parallel write not issued");
  par_refused_a: assert property (!port_type_select_i && $rose(wr_b_i) && cs_b_i
    |-> ##1 !wr_stb_o [*6]) else $error("deselected parallel write issued");
  par_fields_a: assert property (wr_stb_o && !port_type_select_i && !$past(port_type_select_i, 4)
    |-> wr_chan_o == channel_address_i && wr_data_o == data_word_i && !wr_bank_o
    && wr_reg_o == {target_reg_sel_high_i, target_reg_sel_low_i}) else $error("parallel fields wrong");
  ack_window_a: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 3))
    else $error("acknowledge started outside clock low");
  ack_len_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("acknowledge too short");
  ack_hold_a: assert property ($fell(sda_oe_o) |-> !scl_i && $past(scl_i, 6) && !sda_o)
    else $error("acknowledge released in clock high");
  burst_bank_a: assert property (wr_stb_o && port_type_select_i && proto_sel_i |-> !wr_bank_o)
    else $error("two-wire write selected toggle bank");
  off_quiet_a: assert property (!port_type_select_i && !$past(port_type_select_i, 4)
    |-> !readback_out_o && !sda_oe_o) else $error("serial side active in parallel mode");
  // main scenarios reached
  cover property (wr_stb_o && !port_type_select_i);
  cover property ($rose(sda_oe_o));
  cover property (readback_out_o);
endmodule // dhci_top_monitor

bind dhci_top dhci_top_monitor i_dhci_top_monitor (.*);

// [tb/dhci_top_tb.sv]
// testbench of the dac host command interface
`timescale 1ns/1ps
module dhci_top_tb;
  // ----------------------------------------
  // signals, clock, design and host
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_b_i, port_type_select_i, proto_sel_i, sync_b_i, sclk_i, din_i, readback_out_o;
  logic scl_i, sda_i, sda_o, sda_oe_o, sda_low, addr_strap_high_i, addr_strap_low_i;
  logic cs_b_i, wr_b_i, target_reg_sel_high_i, target_reg_sel_low_i, rd_bank_o, wr_stb_o, wr_bank_o;
  logic [5:0] channel_address_i, rd_chan_o, wr_chan_o;
  logic [1:0] rd_reg_o, wr_reg_o;
  logic [13:0] data_word_i, rd_data_i, wr_data_o;
  logic [22:0] wq[$]; // captured write requests
  int mismatches = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  // pulled-up data line, register store lookup
  assign sda_i = (sda_oe_o ? sda_o : 1'b1) & !sda_low;
  assign rd_data_i = {rd_reg_o, rd_chan_o, rd_chan_o};
  dhci_top i_dhci_top (.*);
  dhci_host_model i_dhci_host_model (.clk_i(clk_i), .readback_out_i(readback_out_o), .sda_i(sda_i),
    .sync_b_o(sync_b_i), .sclk_o(sclk_i), .din_o(din_i), .scl_o(scl_i), .sda_low_o(sda_low),
    .cs_b_o(cs_b_i), .wr_b_o(wr_b_i), .reg_sel_o({target_reg_sel_high_i, target_reg_sel_low_i}),
    .chan_o(channel_address_i), .data_o(data_word_i));
  // collect every write request
  always @(posedge clk_i)
    if (wr_stb_o === 1'b1)
      wq.push_back({wr_bank_o, wr_chan_o, wr_reg_o, wr_data_o});
  // ----------------------------------------
  // compare, bus helpers and closing
  // ----------------------------------------
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // oldest write request against expectation
  task automatic cmp_wr(input logic [22:0] e);
    logic [22:0] g;
    g = 'x;
    if (wq.size() != 0)
      g = wq.pop_front();
    cmp_val({9'h000, g}, {9'h000, e});
  endtask
  // one two-wire byte and its expected ninth-bit level
  task automatic tw_send(input logic [7:0] b, input logic e);
    logic a;
    i_dhci_host_model.tw_byte(b, a);
    cmp_val({31'h0, a}, {31'h0, e});
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, tests need about 0.2 ms
  initial
  begin
    #600000;
    mismatches++;
    wrap_up();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    logic [23:0] rb;
    logic [23:0] rq;
    rst_b_i = 1'b0;
    {port_type_select_i, proto_sel_i, addr_strap_high_i, addr_strap_low_i} = 4'h2;
    repeat (8) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    i_dhci_host_model.tick(6);
    // parallel port: selected write, then deselected write
    i_dhci_host_model.par_write(1'b0, 2'h3, 6'h27, 14'h2A5C);
    cmp_wr({1'b0, 6'h27, 2'h3, 14'h2A5C});
    i_dhci_host_model.par_write(1'b1, 2'h1, 6'h05, 14'h1111);
    cmp_val(wq.size(), 0);
    // three-wire serial: write, short frame, readback
    port_type_select_i = 1'b1;
    i_dhci_host_model.tick(8);
    i_dhci_host_model.par_write(1'b0, 2'h1, 6'h05, 14'h1111);
    i_dhci_host_model.spi_frame({1'b1, 1'b0, 6'h1B, 2'h2, 14'h2345}, 24, rb);
    cmp_wr({1'b1, 6'h1B, 2'h2, 14'h2345});
    i_dhci_host_model.spi_frame({1'b0, 1'b0, 6'h01, 2'h1, 14'h0001}, 10, rb);
    cmp_val(wq.size(), 0);
    rq = {1'b1, 1'b1, 6'h27, 2'h1, 14'h0ABC};
    i_dhci_host_model.spi_frame(rq, 24, rb);
    cmp_val(wq.size(), 0);
    cmp_val({31'h0, rd_bank_o}, {31'h0, rq[23]});
    i_dhci_host_model.spi_frame(24'h000000, 24, rb);
    cmp_val({8'h00, rb}, {8'h00, rq[23:14], 2'h1, 6'h27, 6'h27});
    wq.delete();
    // two-wire: four-byte, three-byte, repeated start
    proto_sel_i = 1'b1;
    i_dhci_host_model.tick(8);
    i_dhci_host_model.tw_start();
    tw_send(8'hAC, 1'b0);
    tw_send(8'h07, 1'b0);
    tw_send(8'h9A, 1'b0);
    tw_send(8'hBC, 1'b0);
    tw_send(8'h21, 1'b0);
    tw_send(8'h41, 1'b0);
    tw_send(8'h23, 1'b0);
    i_dhci_host_model.tw_start();
    tw_send(8'hAC, 1'b0);
    tw_send(8'h02, 1'b0);
    tw_send(8'h00, 1'b0);
    tw_send(8'h55, 1'b0);
    i_dhci_host_model.tw_stop();
    cmp_wr({1'b0, 6'h07, 2'h2, 14'h1ABC});
    cmp_wr({1'b0, 6'h21, 2'h1, 14'h0123});
    cmp_wr({1'b0, 6'h02, 2'h0, 14'h0055});
    // foreign address and read direction refused
    i_dhci_host_model.tw_start();
    tw_send(8'hAA, 1'b1);
    tw_send(8'h07, 1'b1);
    i_dhci_host_model.tw_start();
    tw_send(8'hAD, 1'b1);
    i_dhci_host_model.tw_stop();
    cmp_val(wq.size(), 0);
    // burst over all channels, then back to pointer mode
    i_dhci_host_model.tw_start();
    tw_send(8'hAC, 1'b0);
    tw_send(8'hFF, 1'b0);
    for (int ch = 0; ch < 40; ch++)
    begin
      tw_send({ch[1:0], 6'h15}, 1'b0);
      tw_send(ch[7:0], 1'b0);
      cmp_wr({1'b0, ch[5:0], ch[1:0], 6'h15, ch[7:0]});
    end
    tw_send(8'h03, 1'b0);
    tw_send(8'h80, 1'b0);
    tw_send(8'h07, 1'b0);
    i_dhci_host_model.tw_stop();
    cmp_wr({1'b0, 6'h03, 2'h2, 14'h0007});
    // stop ends burst: next transaction needs a pointer
    i_dhci_host_model.tw_start();
    tw_send(8'hAC, 1'b0);
    tw_send(8'hFF, 1'b0);
    tw_send(8'h00, 1'b0);
    tw_send(8'h11, 1'b0);
    i_dhci_host_model.tw_stop();
    i_dhci_host_model.tw_start();
    tw_send(8'hAC, 1'b0);
    tw_send(8'h05, 1'b0);
    tw_send(8'h40, 1'b0);
    tw_send(8'h22, 1'b0);
    i_dhci_host_model.tw_stop();
    cmp_wr({1'b0, 6'h00, 2'h0, 14'h0011});
    cmp_wr({1'b0, 6'h05, 2'h1, 14'h0022});
    cmp_val(wq.size(), 0);
    wrap_up();
  end
endmodule // dhci_top_tb
